// ===== hdl/idsd_decode.sv
// internal register space decoder: scratchpad ram, bank registers,
// stack pointer, status word and program fetch source
// assumes the core issues at most one access per clock and
// external special function registers answer reads themselves

////////////////////////////////////////////////////////////////////////
// Functional notes
// - register space is its own space, reached only by access ops
// - direct access to 80h..FFh selects special function registers
// - indirect access to 128..255 selects upper scratchpad ram
// - direct access to 0..7Fh selects lower scratchpad ram
// - ram bytes 20h..2Fh also reachable as 128 single bits
// - special registers at addresses ending 0 or 8 are bit addressable
// - bit versus byte access chosen by op type, not by address
// - four banks of eight working registers, bank chosen by status word
// - first two bank registers serve as 8-bit indirect pointers
// - stack pointer at 81h resets to 07h, software may rewrite it
// - pointer marks last used entry; push pre-increments, pop post-decrements
// - push and call raise pointer per byte stored, pop and return lower it
// - fetch starts at program address 0000h after reset
// - strap high: fetches beyond internal size go external
// - strap low: every fetch outside the boot rom windows goes external
// - internal program size is a 4k/8k/16k/32k variant parameter
// - user mode with boot enabled: boot rom at F800h..FFFFh overrides
// - programming mode: boot rom answers in lowest 2 kB
module idsd_decode #(
    parameter int INT_PROG_KB = idsd_pkg::INT_PROG_KB_DFLT
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire idsd_pkg::idsd_op_t acc_op_i,
    input wire logic acc_we_i,
    input wire logic [7:0] acc_addr_i,
    input wire logic [7:0] acc_wdata_i,
    input wire logic acc_bit_i,
    input wire logic pc_load_i,
    input wire logic [15:0] pc_load_val_i,
    input wire logic pc_inc_i,
    input wire logic external_fetch_strap_i,
    input wire logic prog_mode_i,
    input wire logic boot_en_i,
    output logic rd_valid_o,
    output logic [7:0] rd_data_o,
    output logic rd_bit_o,
    output logic sfr_re_o,
    output logic sfr_we_o,
    output logic sfr_bit_o,
    output logic [2:0] sfr_bit_sel_o,
    output logic [7:0] sfr_addr_o,
    output logic [7:0] sfr_wdata_o,
    output logic [7:0] stack_pointer_o,
    output logic [7:0] program_status_word_o,
    output logic [15:0] program_counter_o,
    output idsd_pkg::idsd_src_t fetch_src_o
);

    ////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic [7:0] bank_index(
        input logic [1:0] bank,
        input logic [2:0] r
    );
        return {3'b000, bank, r};
    endfunction

    // bit address to the byte that holds it
    function automatic logic [7:0] bit_byte(input logic [7:0] a);
        logic [7:0] b;
        b = a[7] ? {a[7:3], 3'b000} : 8'(idsd_pkg::BIT_RAM_BASE + a[6:3]);
        return b;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // state

    logic [7:0] ram [256];
    logic [7:0] sp_q, sp_d;
    logic [7:0] psw_q, psw_d;
    logic [15:0] pc_q, pc_d;
    logic rd_valid_q, rd_valid_d;
    logic [7:0] rd_data_q, rd_data_d;
    logic rd_bit_q, rd_bit_d;
    logic sfr_re_q, sfr_re_d;
    logic sfr_we_q, sfr_we_d;
    logic sfr_bit_q, sfr_bit_d;
    logic [2:0] sfr_sel_q, sfr_sel_d;
    logic [7:0] sfr_addr_q, sfr_addr_d;
    logic [7:0] sfr_wdata_q, sfr_wdata_d;
    idsd_pkg::idsd_src_t src_q;
    logic strap_meta_q, strap_q;

    logic [1:0] bank;
    logic in_sfr;
    logic [7:0] byte_a;
    logic [7:0] cur;
    logic [7:0] nxt;
    logic ram_we;
    logic is_write;

    idsd_fetch_if fif ();

    idsd_fetch_sel #(
        .INT_PROG_KB(INT_PROG_KB)
    ) u_sel (
        .f(fif.sel)
    );

    assign bank = psw_q[idsd_pkg::PSW_BANK_HI:idsd_pkg::PSW_BANK_LO];
    assign fif.pc = pc_q;
    assign fif.strap_high = strap_q;
    assign fif.prog_mode = prog_mode_i;
    assign fif.boot_en = boot_en_i;

    ////////////////////////////////////////////////////////////////////
    // space and byte selection

    always_comb begin
        in_sfr = 1'b0;
        byte_a = acc_addr_i;
        unique case (acc_op_i)
            idsd_pkg::IDSD_OP_NONE: begin
                byte_a = acc_addr_i;
            end
            idsd_pkg::IDSD_OP_DIR: begin
                in_sfr = acc_addr_i[7];
            end
            idsd_pkg::IDSD_OP_IND: begin
                in_sfr = 1'b0;
            end
            idsd_pkg::IDSD_OP_PTR: begin
                byte_a = ram[bank_index(bank, {2'b00, acc_addr_i[0]})];
            end
            idsd_pkg::IDSD_OP_REG: begin
                byte_a = bank_index(bank, acc_addr_i[2:0]);
            end
            idsd_pkg::IDSD_OP_BIT: begin
                in_sfr = acc_addr_i[7];
                byte_a = bit_byte(acc_addr_i);
            end
            idsd_pkg::IDSD_OP_PUSH: begin
                byte_a = 8'(sp_q + 8'h01);
            end
            idsd_pkg::IDSD_OP_POP: begin
                byte_a = sp_q;
            end
        endcase
    end

    // current byte: ram, one of the two local special registers, or 00h for other special registers
    always_comb begin
        cur = ram[byte_a];
        if (in_sfr) begin
            if (byte_a == idsd_pkg::SP_ADDR) begin
                cur = sp_q;
            end else if (byte_a == idsd_pkg::PSW_ADDR) begin
                cur = psw_q;
            end else begin
                cur = 8'h00;
            end
        end
        is_write = acc_we_i || acc_op_i == idsd_pkg::IDSD_OP_PUSH;
        is_write = is_write && acc_op_i != idsd_pkg::IDSD_OP_POP;
        is_write = is_write && acc_op_i != idsd_pkg::IDSD_OP_NONE;
        nxt = acc_wdata_i;
        if (acc_op_i == idsd_pkg::IDSD_OP_BIT) begin
            nxt = cur;
            nxt[acc_addr_i[2:0]] = acc_bit_i;
        end
        ram_we = is_write && !in_sfr;
    end

    ////////////////////////////////////////////////////////////////////
    // next state of registers and answers

    logic local_sfr;
    assign local_sfr = byte_a == idsd_pkg::SP_ADDR
        || byte_a == idsd_pkg::PSW_ADDR;

    always_comb begin
        sp_d = sp_q;
        psw_d = psw_q;
        if (acc_op_i == idsd_pkg::IDSD_OP_PUSH) begin
            sp_d = 8'(sp_q + 8'h01);
        end else if (acc_op_i == idsd_pkg::IDSD_OP_POP) begin
            sp_d = 8'(sp_q - 8'h01);
        end else if (is_write && in_sfr) begin
            if (byte_a == idsd_pkg::SP_ADDR) begin
                sp_d = nxt;
            end
            if (byte_a == idsd_pkg::PSW_ADDR) begin
                psw_d = nxt;
            end
        end
    end

    always_comb begin
        rd_valid_d = 1'b0;
        rd_data_d = rd_data_q;
        rd_bit_d = rd_bit_q;
        sfr_re_d = 1'b0;
        sfr_we_d = 1'b0;
        sfr_bit_d = 1'b0;
        sfr_sel_d = sfr_sel_q;
        sfr_addr_d = sfr_addr_q;
        sfr_wdata_d = sfr_wdata_q;
        if (acc_op_i != idsd_pkg::IDSD_OP_NONE) begin
            if (in_sfr && !local_sfr) begin
                // external register: forward, the owner answers reads
                sfr_re_d = !is_write;
                sfr_we_d = is_write;
                sfr_bit_d = acc_op_i == idsd_pkg::IDSD_OP_BIT;
                sfr_sel_d = acc_addr_i[2:0];
                sfr_addr_d = byte_a;
                sfr_wdata_d = acc_wdata_i;
                if (acc_op_i == idsd_pkg::IDSD_OP_BIT) begin
                    sfr_wdata_d = {7'h00, acc_bit_i};
                end
            end else if (!is_write) begin
                rd_valid_d = 1'b1;
                rd_data_d = cur;
                rd_bit_d = cur[acc_addr_i[2:0]];
            end
        end
    end

    always_comb begin
        pc_d = pc_q;
        if (pc_load_i) begin
            pc_d = pc_load_val_i;
        end else if (pc_inc_i) begin
            pc_d = 16'(pc_q + 16'h0001);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clk_i) begin
        if (ram_we) begin
            ram[byte_a] <= nxt;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sp_q <= idsd_pkg::SP_RST;
            psw_q <= idsd_pkg::PSW_RST;
            pc_q <= idsd_pkg::PC_RST;
            rd_valid_q <= 1'b0;
            rd_data_q <= 8'h00;
            rd_bit_q <= 1'b0;
            sfr_re_q <= 1'b0;
            sfr_we_q <= 1'b0;
            sfr_bit_q <= 1'b0;
            sfr_sel_q <= 3'h0;
            sfr_addr_q <= 8'h00;
            sfr_wdata_q <= 8'h00;
            src_q <= idsd_pkg::IDSD_SRC_EXT;
            strap_meta_q <= 1'b0;
            strap_q <= 1'b0;
        end else begin
            sp_q <= sp_d;
            psw_q <= psw_d;
            pc_q <= pc_d;
            rd_valid_q <= rd_valid_d;
            rd_data_q <= rd_data_d;
            rd_bit_q <= rd_bit_d;
            sfr_re_q <= sfr_re_d;
            sfr_we_q <= sfr_we_d;
            sfr_bit_q <= sfr_bit_d;
            sfr_sel_q <= sfr_sel_d;
            sfr_addr_q <= sfr_addr_d;
            sfr_wdata_q <= sfr_wdata_d;
            src_q <= fif.src;
            // the strap is a pin: two stages before use
            strap_meta_q <= external_fetch_strap_i;
            strap_q <= strap_meta_q;
        end
    end

    assign rd_valid_o = rd_valid_q;
    assign rd_data_o = rd_data_q;
    assign rd_bit_o = rd_bit_q;
    assign sfr_re_o = sfr_re_q;
    assign sfr_we_o = sfr_we_q;
    assign sfr_bit_o = sfr_bit_q;
    assign sfr_bit_sel_o = sfr_sel_q;
    assign sfr_addr_o = sfr_addr_q;
    assign sfr_wdata_o = sfr_wdata_q;
    assign stack_pointer_o = sp_q;
    assign program_status_word_o = psw_q;
    assign program_counter_o = pc_q;
    assign fetch_src_o = src_q;

    ////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_push;
        acc_op_i == idsd_pkg::IDSD_OP_PUSH;
    endsequence

    sequence s_pop;
        acc_op_i == idsd_pkg::IDSD_OP_POP;
    endsequence

    chk_push_stores: assert property (
        s_push |=> sp_q == 8'($past(sp_q) + 8'h01)
            && ram[sp_q] == $past(acc_wdata_i))
        else $error("push did not store above the pointer");

    chk_pop_reads: assert property (
        s_pop |=> rd_valid_q
            && rd_data_q == ram[8'(sp_q + 8'h01)]
            && sp_q == 8'($past(sp_q) - 8'h01))
        else $error("pop did not read then decrement");

    chk_upper_ind: assert property (
        acc_op_i == idsd_pkg::IDSD_OP_IND && acc_addr_i[7] && acc_we_i
            |=> !sfr_we_q && ram[$past(acc_addr_i)] == $past(acc_wdata_i))
        else $error("indirect upper access reached the register space");

    chk_direct_sfr: assert property (
        acc_op_i == idsd_pkg::IDSD_OP_DIR && acc_addr_i[7] && !local_sfr
            |=> (sfr_re_q || sfr_we_q) && sfr_addr_o == $past(acc_addr_i))
        else $error("direct upper access missed the register space");

    chk_bank_write: assert property (
        acc_op_i == idsd_pkg::IDSD_OP_REG && acc_we_i
            |=> ram[{3'b000, $past(bank), $past(acc_addr_i[2:0])}]
                == $past(acc_wdata_i))
        else $error("bank register write went to the wrong byte");

    chk_bit_ram: assert property (
        acc_op_i == idsd_pkg::IDSD_OP_BIT && !acc_addr_i[7] && acc_we_i
            |=> ram[$past(byte_a)][$past(acc_addr_i[2:0])]
                == $past(acc_bit_i))
        else $error("ram bit write lost");

    chk_sp_reset: assert property (
        @(posedge clk_i) $rose(rst_n_i) |-> sp_q == idsd_pkg::SP_RST
            && pc_q == idsd_pkg::PC_RST)
        else $error("stack pointer or program counter wrong after reset");

    chk_strap_low: assert property (
        (!external_fetch_strap_i && !prog_mode_i && !boot_en_i) [*3]
            |=> fetch_src_o == idsd_pkg::IDSD_SRC_EXT)
        else $error("strap low but fetch not external");

endmodule

// ===== common/idsd_pkg.sv
// constants and types for the internal data space decoder
// assumes one system clock; all users name items as idsd_pkg::name
package idsd_pkg;

    localparam logic [7:0] SP_ADDR = 8'h81;
    localparam logic [7:0] PSW_ADDR = 8'hd0;
    localparam logic [7:0] SP_RST = 8'h07;
    localparam logic [7:0] PSW_RST = 8'h00;
    localparam logic [7:0] BIT_RAM_BASE = 8'h20;
    localparam int PSW_BANK_LO = 3;
    localparam int PSW_BANK_HI = 4;
    localparam logic [15:0] PC_RST = 16'h0000;
    localparam logic [15:0] BOOT_HI_BASE = 16'hf800;
    localparam logic [15:0] BOOT_SIZE = 16'h0800;
    localparam int INT_PROG_KB_DFLT = 32;
    localparam int KB = 1024;

    // access class decided by the issuing instruction, never by address
    typedef enum logic [2:0] {
        IDSD_OP_NONE,
        IDSD_OP_DIR,
        IDSD_OP_IND,
        IDSD_OP_PTR,
        IDSD_OP_REG,
        IDSD_OP_BIT,
        IDSD_OP_PUSH,
        IDSD_OP_POP
    } idsd_op_t;

    typedef enum logic [1:0] {
        IDSD_SRC_INT,
        IDSD_SRC_EXT,
        IDSD_SRC_BOOT
    } idsd_src_t;

endpackage

// ===== common/idsd_fetch_if.sv
// carrier between the decoder top and its fetch source selector
// assumes both ends sit on the same clock
interface idsd_fetch_if;
    logic [15:0] pc;
    logic strap_high;
    logic prog_mode;
    logic boot_en;
    idsd_pkg::idsd_src_t src;

    modport core (
        output pc,
        output strap_high,
        output prog_mode,
        output boot_en,
        input src
    );

    modport sel (
        input pc,
        input strap_high,
        input prog_mode,
        input boot_en,
        output src
    );
endinterface

// ===== hdl/idsd_fetch_sel.sv
// program fetch source selection: internal flash, external or boot rom
// assumes inputs are already synchronised to the system clock
module idsd_fetch_sel #(
    parameter int INT_PROG_KB = idsd_pkg::INT_PROG_KB_DFLT
) (
    idsd_fetch_if.sel f
);

    localparam logic [16:0] INT_TOP = 17'(INT_PROG_KB * idsd_pkg::KB);

    function automatic idsd_pkg::idsd_src_t pick(
        input logic [15:0] pc,
        input logic strap,
        input logic pmode,
        input logic boot
    );
        idsd_pkg::idsd_src_t s;
        s = idsd_pkg::IDSD_SRC_INT;
        if (pmode && pc < idsd_pkg::BOOT_SIZE) begin
            s = idsd_pkg::IDSD_SRC_BOOT;
        end else if (!pmode && boot && pc >= idsd_pkg::BOOT_HI_BASE) begin
            s = idsd_pkg::IDSD_SRC_BOOT;
        end else if (!strap) begin
            s = idsd_pkg::IDSD_SRC_EXT;
        end else if ({1'b0, pc} >= INT_TOP) begin
            s = idsd_pkg::IDSD_SRC_EXT;
        end
        return s;
    endfunction

    always_comb begin
        f.src = pick(f.pc, f.strap_high, f.prog_mode, f.boot_en);
    end

endmodule

// ===== verification/idsd_core_model.sv
// core side model: issues one register space access per call
// assumes the decoder takes requests on the rising clock edge
module idsd_core_model (
    input wire logic clk_i,
    output idsd_pkg::idsd_op_t op_o,
    output logic we_o,
    output logic [7:0] addr_o,
    output logic [7:0] wdata_o,
    output logic bit_o
);
    timeunit 1ns;
    timeprecision 1ps;
    ////////////////////////////////////////////////////////////////////
    initial op_o = idsd_pkg::IDSD_OP_NONE;
    initial {we_o, addr_o, wdata_o, bit_o} = '0;
    // launched after a falling edge, held across the taking edge
    task automatic acc(input idsd_pkg::idsd_op_t op, input logic we,
            input logic [7:0] a, input logic [7:0] d, input logic b);
        op_o = op;
        we_o = we;
        addr_o = a;
        wdata_o = d;
        bit_o = b;
        @(posedge clk_i);
        @(negedge clk_i);
    endtask
    // stale address and data inverted so they never pass as valid
    task automatic idle();
        op_o = idsd_pkg::IDSD_OP_NONE;
        addr_o = ~addr_o;
        wdata_o = ~wdata_o;
        @(negedge clk_i);
    endtask
endmodule

// ===== verification/tb.sv
// self-checking bench for the internal data space decoder
// assumes idsd_pkg, the decoder and the core model compiled first
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int KB_N = 8;
    localparam idsd_pkg::idsd_op_t DIR = idsd_pkg::IDSD_OP_DIR;
    localparam idsd_pkg::idsd_op_t IND = idsd_pkg::IDSD_OP_IND;
    localparam idsd_pkg::idsd_op_t PTR = idsd_pkg::IDSD_OP_PTR;
    localparam idsd_pkg::idsd_op_t REG = idsd_pkg::IDSD_OP_REG;
    localparam idsd_pkg::idsd_op_t BIT = idsd_pkg::IDSD_OP_BIT;
    localparam idsd_pkg::idsd_op_t PSH = idsd_pkg::IDSD_OP_PUSH;
    localparam idsd_pkg::idsd_op_t POP = idsd_pkg::IDSD_OP_POP;
    `define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
        fail_count++; $display("MISMATCH t=%0t got=%h exp=%h", $time, \
        g, e); end end
    ////////////////////////////////////////////////////////////////////
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic pc_ld = 1'b0;
    logic pc_inc = 1'b0;
    logic strap = 1'b1;
    logic pm = 1'b0;
    logic boot = 1'b0;
    logic [15:0] pc_val = 16'h0000;
    idsd_pkg::idsd_op_t op;
    logic we, ab, rv, rb, sre, swe, sbit;
    logic [2:0] ssel;
    logic [7:0] a, wd, rd, saddr, swd, sp_o, psw_o;
    logic [15:0] pc_o, p;
    logic [17:0] e;
    idsd_pkg::idsd_src_t src;
    logic [15:0] pcs [8] = '{16'h0000, 16'h07ff, 16'h0800, 16'h1fff,
        16'h2000, 16'hf7ff, 16'hf800, 16'hffff};
    int fail_count = 0;
    int checks_done = 0;
    int ram [256];
    int d, k, v;

    always #10 clk = ~clk;

    idsd_decode #(.INT_PROG_KB(KB_N)) dut (
        .clk_i(clk), .rst_n_i(rst_n), .acc_op_i(op), .acc_we_i(we),
        .acc_addr_i(a), .acc_wdata_i(wd), .acc_bit_i(ab),
        .pc_load_i(pc_ld), .pc_load_val_i(pc_val), .pc_inc_i(pc_inc),
        .external_fetch_strap_i(strap), .prog_mode_i(pm),
        .boot_en_i(boot), .rd_valid_o(rv), .rd_data_o(rd), .rd_bit_o(rb),
        .sfr_re_o(sre), .sfr_we_o(swe), .sfr_bit_o(sbit),
        .sfr_bit_sel_o(ssel), .sfr_addr_o(saddr), .sfr_wdata_o(swd),
        .stack_pointer_o(sp_o), .program_status_word_o(psw_o),
        .program_counter_o(pc_o), .fetch_src_o(src));
    idsd_core_model core (.clk_i(clk), .op_o(op), .we_o(we),
        .addr_o(a), .wdata_o(wd), .bit_o(ab));

    function automatic logic [8:0] okb(input int x);
        return {1'b1, x[7:0]};
    endfunction
    function automatic idsd_pkg::idsd_src_t want(input logic [15:0] q,
            input logic [2:0] f);
        if (f[1] && q < 16'h0800) return idsd_pkg::IDSD_SRC_BOOT;
        if (!f[1] && f[2] && q >= 16'hf800) return idsd_pkg::IDSD_SRC_BOOT;
        if (!f[0] || q >= KB_N * 1024) return idsd_pkg::IDSD_SRC_EXT;
        return idsd_pkg::IDSD_SRC_INT;
    endfunction
    task automatic rdc(input idsd_pkg::idsd_op_t o, input int x);
        core.acc(o, 1'b0, x[7:0], 8'h00, 1'b0);
    endtask
    // strap passes a two stage synchroniser, so allow a few cycles
    task automatic fetch(input logic [15:0] q, input logic [2:0] f);
        pc_val = q;
        pc_ld = 1'b1;
        {boot, pm, strap} = f;
        @(negedge clk);
        pc_ld = 1'b0;
        repeat (4) @(negedge clk);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        #500_000;
        fail_count++;
        end_of_test();
    end

    initial begin
        void'($urandom(93220));
        repeat (4) @(negedge clk);
        `CHK({sp_o, psw_o}, 16'h0700)
        `CHK(pc_o, 16'h0000)
        rst_n = 1'b1;
        @(negedge clk);
        for (int i = 0; i < 128; i++) begin
            ram[i] = $urandom % 256;
            core.acc(DIR, 1'b1, i[7:0], 8'(ram[i]), 1'b0);
        end
        for (int i = 0; i < 128; i++) begin
            rdc(DIR, i);
            `CHK({sre, rv, rd}, {1'b0, okb(ram[i])})
        end
        $display("test lower_ram done");
        for (int i = 128; i < 256; i++) begin
            ram[i] = $urandom % 256;
            core.acc(IND, 1'b1, i[7:0], 8'(ram[i]), 1'b0);
            `CHK({sre, swe}, 2'b00)
        end
        for (int i = 128; i < 256; i++) begin
            if (i == 'h81 || i == 'hd0) continue;
            d = ~ram[i];
            core.acc(DIR, 1'b1, i[7:0], 8'(d), 1'b0);
            e = {2'b10, i[7:0], d[7:0]};
            `CHK({swe, sbit, saddr, swd}, e)
            rdc(DIR, i);
            `CHK({sre, rv, saddr}, {2'b10, i[7:0]})
        end
        `CHK(sp_o, 8'h07)
        for (int i = 128; i < 256; i++) begin
            rdc(IND, i);
            `CHK({sre, rv, rd}, {1'b0, okb(ram[i])})
        end
        $display("test upper_space done");
        for (int i = 0; i < 128; i++) begin
            v = $urandom % 2;
            core.acc(BIT, 1'b1, i[7:0], 8'h00, v[0]);
            ram['h20 + i / 8][i % 8] = v[0];
        end
        for (int i = 'h20; i < 'h30; i++) begin
            rdc(DIR, i);
            `CHK({rv, rd}, okb(ram[i]))
        end
        for (int i = 0; i < 128; i += 9) begin
            rdc(BIT, i);
            `CHK({rv, rb}, {1'b1, ram['h20 + i / 8][i % 8]})
        end
        for (int i = 'h80; i < 'h100; i += 8) begin
            if (i == 'hd0) continue;
            k = $urandom % 8;
            v = $urandom % 2;
            core.acc(BIT, 1'b1, 8'(i + k), 8'h00, v[0]);
            e = {2'b00, 4'b0011, k[2:0], i[7:0], v[0]};
            `CHK({swe, sbit, ssel, saddr, swd[0]}, e[13:0])
        end
        core.acc(BIT, 1'b1, 8'hd3, 8'h00, 1'b1);
        `CHK(psw_o, 8'h08)
        $display("test bits done");
        for (int n = 0; n < 4; n++) begin
            core.acc(DIR, 1'b1, 8'hd0, 8'(n * 8), 1'b0);
            `CHK(psw_o, 8'(n * 8))
            for (int r = 0; r < 8; r++) begin
                ram[n * 8 + r] = $urandom % 256;
                core.acc(REG, 1'b1, 8'(r), 8'(ram[n * 8 + r]), 1'b0);
                rdc(DIR, n * 8 + r);
                `CHK({rv, rd}, okb(ram[n * 8 + r]))
            end
            rdc(REG, 5);
            `CHK({rv, rd}, okb(ram[n * 8 + 5]))
        end
        core.acc(REG, 1'b1, 8'h00, 8'h9a, 1'b0);
        core.acc(REG, 1'b1, 8'h01, 8'h45, 1'b0);
        d = $urandom % 256;
        core.acc(PTR, 1'b1, 8'h00, 8'(d), 1'b0);
        core.acc(PTR, 1'b1, 8'h01, 8'(~d), 1'b0);
        rdc(IND, 'h9a);
        `CHK({rv, rd}, okb(d))
        rdc(PTR, 1);
        `CHK({rv, rd}, okb(~d))
        $display("test banks done");
        core.acc(DIR, 1'b1, 8'h81, 8'h7e, 1'b0);
        `CHK(sp_o, 8'h7e)
        core.acc(PSH, 1'b1, 8'h00, 8'(d), 1'b0);
        core.acc(PSH, 1'b1, 8'h00, 8'(~d), 1'b0);
        `CHK(sp_o, 8'h80)
        rdc(IND, 'h7f);
        `CHK({rv, rd}, okb(d))
        rdc(POP, 0);
        `CHK({rv, rd}, okb(~d))
        rdc(POP, 0);
        `CHK({rv, rd}, okb(d))
        rdc(DIR, 'h81);
        `CHK({rv, rd}, 9'h17e)
        core.idle();
        $display("test stack done");
        for (int c = 0; c < 64; c++) begin
            p = pcs[c % 8];
            fetch(p, c[5:3]);
            `CHK(src, want(p, c[5:3]))
        end
        fetch(16'h1fff, 3'b001);
        pc_inc = 1'b1;
        @(negedge clk);
        pc_inc = 1'b0;
        repeat (2) @(negedge clk);
        `CHK(pc_o, 16'h2000)
        `CHK(src, idsd_pkg::IDSD_SRC_EXT)
        $display("test fetch done");
        end_of_test();
    end
endmodule
